// ==== scbc_chk_sva.sv ====
`default_nettype none
module scbc_chk
	import scbc_pkg::*;
(
	// system
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// serial bus
	input wire logic       smb_clk,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	// control
	input wire logic       pll_bw_pin,
	input wire logic       cfg_hold,
	input wire scbc_ctrl_t ctrl
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_rst_ctrl: assert property (disable iff (1'b0) !rst_n |-> ctrl == 7'h7F)
		else $error("ctrl not at reset value");
	a_rst_sda: assert property (disable iff (1'b0) !rst_n |-> !sda_oe)
		else $error("data line driven in reset");
	// device lets go of the data line once the bus clock rests high between frames
	a_idle_release: assert property (smb_clk [*8] |-> !sda_oe && !sda_o)
		else $error("data line held while bus idle");
	// device moves the data line only on falling bus clock edges
	a_oe_scl_high: assert property (smb_clk [*3] |-> $stable(sda_oe))
		else $error("data line moved while bus clock high");
	a_src_forces_en: assert property (ctrl.pll_source_select |-> ctrl.pll_enable)
		else $error("pll bypassed under pin control");
	// pin reaches ctrl three cycles late, so it must have held over that span
	a_bw_tracks_pin: assert property ($stable(pll_bw_pin) [*3] ##0 ctrl.pll_source_select
		|-> ctrl.pll_bandwidth_select == pll_bw_pin)
		else $error("bandwidth does not follow pin");
	a_bw_pin_ignored: assert property (!ctrl.pll_source_select [*4] ##0 $changed(pll_bw_pin)
		|-> ##1 $stable(ctrl.pll_bandwidth_select) [*4])
		else $error("bandwidth followed pin under register control");
	// pipeline of drained writes is empty after eight held cycles
	a_ctrl_hold: assert property (cfg_hold [*8] |-> $stable({ctrl.pll_source_select, ctrl.pll_enable,
		ctrl.out5_gate, ctrl.out3_gate, ctrl.out2_gate, ctrl.out0_gate}))
		else $error("ctrl changed while held");
endmodule : scbc_chk

bind scbc_top scbc_chk u_scbc_chk (.clk_sys, .rst_n, .smb_clk, .sda_i, .sda_o, .sda_oe, .pll_bw_pin,
	.cfg_hold, .ctrl);
`default_nettype wire

// ==== scbc_host.sv ====
`default_nettype none
module scbc_host (
	// bus
	output logic      scl,
	output logic      pull,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;

	// clock idles high and stands still between frames
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end

	task automatic clk_bit(input logic b, output logic s);
		#2 pull = !b;
		#5.5 scl = 1'b1;
		s = sda;
		#7.5 scl = 1'b0;
	endtask : clk_bit

	// odd hold times keep bus edges off the system clock edges
	task automatic bus_start;
		#501 pull = 1'b1;
		#301 scl = 1'b0;
	endtask : bus_start

	task automatic bus_rstart;
		#2 pull = 1'b0;
		#5.5 scl = 1'b1;
		#20 pull = 1'b1;
		#20 scl = 1'b0;
	endtask : bus_rstart

	task automatic bus_stop;
		#2 pull = 1'b1;
		#5.5 scl = 1'b1;
		#301 pull = 1'b0;
	endtask : bus_stop

	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, s);
		ack = !s;
	endtask : put

	task automatic get(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			b[i] = s;
		end
		clk_bit(last, s);
	endtask : get
endmodule : scbc_host
`default_nettype wire

// ==== scbc_pkg.sv ====
`default_nettype none
package scbc_pkg;

	// bus addresses (write, read)
	localparam logic [7:0] ADDR_WR = 8'hD4;
	localparam logic [7:0] ADDR_RD = 8'hD5;

	// register offsets
	localparam logic [7:0] OFS_PLL  = 8'h00;
	localparam logic [7:0] OFS_OEN  = 8'h01;
	localparam logic [7:0] OFS_RSV  = 8'h02;
	localparam logic [7:0] OFS_ID   = 8'h03;
	localparam logic [7:0] OFS_PART = 8'h04;
	localparam logic [7:0] OFS_LEN  = 8'h05;

	// field positions
	localparam int PLL_SRC_BIT = 7;
	localparam int PLL_BW_BIT  = 1;
	localparam int PLL_EN_BIT  = 0;
	localparam int OUT5_BIT    = 5;
	localparam int OUT3_BIT    = 3;
	localparam int OUT2_BIT    = 2;
	localparam int OUT0_BIT    = 0;
	localparam int REV_LSB     = 4;
	localparam int MAKER_LSB   = 0;

	// reset values
	localparam logic [7:0] RST_PLL = 8'h83;
	localparam logic [7:0] RST_OEN = 8'h2D;
	localparam logic [7:0] RST_RSV = 8'h00;
	localparam logic [7:0] RST_LEN = 8'h06;

	// clk_sys cycles of both lines high that mark the bus free
	localparam logic [3:0] IDLE_CYC   = 4'h4;
	localparam int         FIFO_DEPTH = 32;

	typedef struct packed {
		logic [2:0] idx;
		logic [7:0] data;
	} scbc_wr_t;

	typedef struct packed {
		logic pll_source_select;
		logic pll_bandwidth_select;
		logic pll_enable;
		logic out5_gate;
		logic out3_gate;
		logic out2_gate;
		logic out0_gate;
	} scbc_ctrl_t;

	typedef enum logic [2:0] {
		LS_IDLE,
		LS_ADDR,
		LS_INDEX,
		LS_COUNT,
		LS_WDATA,
		LS_RDATA,
		LS_SKIP
	} scbc_link_st_t;

endpackage : scbc_pkg
`default_nettype wire

// ==== scbc_top.sv ====
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// dual-clock fifo, gray pointers; DEPTH a power of two, at least 4
module scbc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// write side
	input  wire logic             wclk,
	input  wire logic             wrst_n,
	input  wire logic             w_valid,
	output logic                  w_ready,
	input  wire logic [WIDTH-1:0] w_data,
	// read side
	input  wire logic             rclk,
	input  wire logic             rrst_n,
	output logic                  r_valid,
	input  wire logic             r_ready,
	output logic [WIDTH-1:0]      r_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin_q, wbin_d, wgray_q, wgray_d;
	logic [AW:0]      rbin_q, rbin_d, rgray_q, rgray_d;
	logic [AW:0]      rgray_w1_q, rgray_w2_q, wgray_r1_q, wgray_r2_q;

	assign w_ready = wgray_q != {~rgray_w2_q[AW:AW-1], rgray_w2_q[AW-2:0]};
	assign r_valid = rgray_q != wgray_r2_q;
	assign r_data  = mem[rbin_q[AW-1:0]];

	always_comb begin
		wbin_d  = wbin_q + {{AW{1'b0}}, w_valid & w_ready};
		wgray_d = wbin_d ^ (wbin_d >> 1);
		rbin_d  = rbin_q + {{AW{1'b0}}, r_valid & r_ready};
		rgray_d = rbin_d ^ (rbin_d >> 1);
	end

	always_ff @(posedge wclk) begin
		if (w_valid && w_ready) begin
			mem[wbin_q[AW-1:0]] <= w_data;
		end
	end

	always_ff @(posedge wclk or negedge wrst_n) begin
		if (!wrst_n) begin
			wbin_q     <= '0;
			wgray_q    <= '0;
			rgray_w1_q <= '0;
			rgray_w2_q <= '0;
		end else begin
			wbin_q     <= wbin_d;
			wgray_q    <= wgray_d;
			rgray_w1_q <= rgray_q;
			rgray_w2_q <= rgray_w1_q;
		end
	end

	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			rbin_q     <= '0;
			rgray_q    <= '0;
			wgray_r1_q <= '0;
			wgray_r2_q <= '0;
		end else begin
			rbin_q     <= rbin_d;
			rgray_q    <= rgray_d;
			wgray_r1_q <= wgray_q;
			wgray_r2_q <= wgray_r1_q;
		end
	end
endmodule : scbc_fifo

////////////////////////////////////////////////////////////////////////////////
module scbc_top
	import scbc_pkg::*;
#(
	parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
	parameter logic [3:0] MAKER_CODE    = 4'h5, // arbitrary value
	parameter logic [7:0] PART_CODE     = 8'hA7, // arbitrary value
	parameter int         WR_DEPTH      = FIFO_DEPTH
) (
	// system
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// serial bus
	input  wire logic smb_clk,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	// pins and local control
	input  wire logic pll_bw_pin,
	input  wire logic cfg_hold,
	// clock path control
	output scbc_ctrl_t ctrl
);
	////////////////////////////////////////////////////////////////////////////
	// system side: pin sampling and bus-free detection
	logic [1:0] scl_sync_q, sda_sync_q, bw_sync_q;
	logic [3:0] hi_cnt_q, hi_cnt_d;
	logic       act_q, act_d;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			bw_sync_q  <= 2'h3; // matches the bandwidth reset value, so no dip after reset
		end else begin
			scl_sync_q <= {scl_sync_q[0], smb_clk};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			bw_sync_q  <= {bw_sync_q[0], pll_bw_pin};
		end
	end

	// act_q releases the link logic at a start and holds it reset while the bus is free
	always_comb begin
		hi_cnt_d = hi_cnt_q;
		act_d    = act_q;
		if (!(scl_sync_q[1] && sda_sync_q[1])) begin
			hi_cnt_d = 4'h0;
		end else if (hi_cnt_q != IDLE_CYC) begin
			hi_cnt_d = 4'(hi_cnt_q + 4'h1);
		end
		if (hi_cnt_q == IDLE_CYC) begin
			act_d = 1'b0;
		end
		if (!act_q && scl_sync_q[1] && !sda_sync_q[1]) begin
			act_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt_q <= 4'h0;
			act_q    <= 1'b0;
		end else begin
			hi_cnt_q <= hi_cnt_d;
			act_q    <= act_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link side: bit sampling on the rising edge
	logic [7:0]    shift_q, shift_d;
	logic          sda_pos_q, sda_pos_d;
	logic [3:0]    cnt_q, cnt_d;
	scbc_link_st_t st_q, st_d;

	always_comb begin
		sda_pos_d = sda_i;
		shift_d   = cnt_q[3] ? shift_q : {shift_q[6:0], sda_i};
	end

	always_ff @(posedge smb_clk or negedge act_q) begin
		if (!act_q) begin
			shift_q   <= 8'h00;
			sda_pos_q <= 1'b1;
		end else begin
			shift_q   <= shift_d;
			sda_pos_q <= sda_pos_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link side: byte sequencing on the falling edge
	logic [7:0] idx_q, idx_d, left_q, left_d, tx_q, tx_d, rd_cur;
	logic       drive_q, drive_d, first_q, first_d, have_idx_q, have_idx_d;
	logic       push_q, push_d, sh_we, w_ready;
	scbc_wr_t   wr_q, wr_d;
	logic [7:0] pll_sh_q, pll_sh_d, oen_sh_q, oen_sh_d, rsv_sh_q, rsv_sh_d, len_sh_q, len_sh_d;

	function automatic logic writable(input logic [7:0] i);
		writable = (i == OFS_PLL) || (i == OFS_OEN) || (i == OFS_RSV) || (i == OFS_LEN);
	endfunction : writable

	function automatic logic [7:0] rd_byte(input logic [7:0] i);
		case (i)
			OFS_PLL:  rd_byte = pll_sh_q;
			OFS_OEN:  rd_byte = oen_sh_q;
			OFS_RSV:  rd_byte = rsv_sh_q;
			OFS_ID:   rd_byte = {REVISION_CODE, MAKER_CODE};
			OFS_PART: rd_byte = PART_CODE;
			OFS_LEN:  rd_byte = len_sh_q;
			default:  rd_byte = 8'h00;
		endcase
	endfunction : rd_byte

	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		idx_d      = idx_q;
		left_d     = left_q;
		tx_d       = tx_q;
		drive_d    = drive_q;
		first_d    = first_q;
		have_idx_d = have_idx_q;
		wr_d       = wr_q;
		push_d     = 1'b0;
		sh_we      = 1'b0;
		rd_cur     = rd_byte(idx_q);
		if (st_q == LS_IDLE || (sda_pos_q && !sda_i)) begin
			// fresh or repeated start
			st_d    = LS_ADDR;
			cnt_d   = 4'h0;
			drive_d = 1'b0;
		end else if (!sda_pos_q && sda_i) begin
			st_d    = LS_SKIP;
			drive_d = 1'b0;
		end else if (st_q == LS_SKIP) begin
			drive_d = 1'b0;
		end else if (cnt_q < 4'h7) begin
			cnt_d = 4'(cnt_q + 4'h1);
			if (st_q == LS_RDATA) begin
				drive_d = ~tx_q[6];
				tx_d    = {tx_q[6:0], 1'b0};
			end
		end else if (cnt_q == 4'h7) begin
			cnt_d   = 4'h8;
			drive_d = 1'b0;
			case (st_q)
				LS_ADDR: begin
					if (shift_q == ADDR_WR) begin
						drive_d = 1'b1;
						st_d    = LS_INDEX;
					end else if (shift_q == ADDR_RD && have_idx_q) begin
						drive_d = 1'b1;
						st_d    = LS_RDATA;
						first_d = 1'b1;
					end else begin
						st_d = LS_SKIP;
					end
				end
				LS_INDEX: begin
					drive_d    = 1'b1;
					idx_d      = shift_q;
					have_idx_d = 1'b1;
					st_d       = LS_COUNT;
				end
				LS_COUNT: begin
					drive_d = 1'b1;
					left_d  = shift_q;
					st_d    = LS_WDATA;
				end
				LS_WDATA: begin
					// a full fifo refuses the byte with a not-acknowledge
					if (left_q != 8'h00 && (w_ready || !writable(idx_q))) begin
						drive_d = 1'b1;
						idx_d   = 8'(idx_q + 8'h01);
						left_d  = 8'(left_q - 8'h01);
						if (writable(idx_q)) begin
							push_d = 1'b1;
							sh_we  = 1'b1;
							wr_d   = '{idx: idx_q[2:0], data: shift_q};
						end
					end
				end
				default: ;
			endcase
		end else begin
			cnt_d   = 4'h0;
			drive_d = 1'b0;
			if (st_q == LS_RDATA) begin
				if (first_q) begin
					first_d = 1'b0;
					tx_d    = len_sh_q;
					drive_d = ~len_sh_q[7];
					left_d  = len_sh_q;
				end else if (!sda_pos_q && left_q != 8'h00) begin
					tx_d    = rd_cur;
					drive_d = ~rd_cur[7];
					idx_d   = 8'(idx_q + 8'h01);
					left_d  = 8'(left_q - 8'h01);
				end else begin
					st_d = LS_SKIP;
				end
			end
		end
	end

	always_ff @(negedge smb_clk or negedge act_q) begin
		if (!act_q) begin
			st_q       <= LS_IDLE;
			cnt_q      <= 4'h0;
			idx_q      <= 8'h00;
			left_q     <= 8'h00;
			tx_q       <= 8'h00;
			drive_q    <= 1'b0;
			first_q    <= 1'b0;
			have_idx_q <= 1'b0;
			push_q     <= 1'b0;
			wr_q       <= '0;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			idx_q      <= idx_d;
			left_q     <= left_d;
			tx_q       <= tx_d;
			drive_q    <= drive_d;
			first_q    <= first_d;
			have_idx_q <= have_idx_d;
			push_q     <= push_d;
			wr_q       <= wr_d;
		end
	end

	assign sda_o  = 1'b0;
	assign sda_oe = drive_q;

	// link-side copy for readback; survives between frames
	always_comb begin
		pll_sh_d = pll_sh_q;
		oen_sh_d = oen_sh_q;
		rsv_sh_d = rsv_sh_q;
		len_sh_d = len_sh_q;
		if (sh_we) begin
			case (idx_q)
				OFS_PLL: pll_sh_d = shift_q;
				OFS_OEN: oen_sh_d = shift_q;
				OFS_RSV: rsv_sh_d = shift_q;
				OFS_LEN: len_sh_d = shift_q;
				default: ;
			endcase
		end
	end

	always_ff @(negedge smb_clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_sh_q <= RST_PLL;
			oen_sh_q <= RST_OEN;
			rsv_sh_q <= RST_RSV;
			len_sh_q <= RST_LEN;
		end else begin
			pll_sh_q <= pll_sh_d;
			oen_sh_q <= oen_sh_d;
			rsv_sh_q <= rsv_sh_d;
			len_sh_q <= len_sh_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write path into the system domain; cfg_hold defers updates
	scbc_wr_t   rd_word;
	logic       r_valid, r_ready;
	logic [7:0] pll_q, pll_d, oen_q, oen_d;
	scbc_ctrl_t ctrl_d;

	assign r_ready = ~cfg_hold;

	scbc_fifo #(
		.WIDTH ($bits(scbc_wr_t)),
		.DEPTH (WR_DEPTH)
	) u_wr_fifo (
		.wclk    (smb_clk),
		.wrst_n  (rst_n),
		.w_valid (push_q),
		.w_ready (w_ready),
		.w_data  (wr_q),
		.rclk    (clk_sys),
		.rrst_n  (rst_n),
		.r_valid (r_valid),
		.r_ready (r_ready),
		.r_data  (rd_word)
	);

	always_comb begin
		pll_d = pll_q;
		oen_d = oen_q;
		if (r_valid && r_ready) begin
			if ({5'h00, rd_word.idx} == OFS_PLL) begin
				pll_d = rd_word.data;
			end
			if ({5'h00, rd_word.idx} == OFS_OEN) begin
				oen_d = rd_word.data;
			end
		end
		ctrl_d.pll_source_select    = pll_q[PLL_SRC_BIT];
		// pin control ignores the register bandwidth and bypass bits
		ctrl_d.pll_bandwidth_select = pll_q[PLL_SRC_BIT] ? bw_sync_q[1] : pll_q[PLL_BW_BIT];
		ctrl_d.pll_enable           = pll_q[PLL_SRC_BIT] | pll_q[PLL_EN_BIT];
		ctrl_d.out5_gate            = oen_q[OUT5_BIT];
		ctrl_d.out3_gate            = oen_q[OUT3_BIT];
		ctrl_d.out2_gate            = oen_q[OUT2_BIT];
		ctrl_d.out0_gate            = oen_q[OUT0_BIT];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pll_q <= RST_PLL;
			oen_q <= RST_OEN;
			ctrl  <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		end else begin
			pll_q <= pll_d;
			oen_q <= oen_d;
			ctrl  <= ctrl_d;
		end
	end
endmodule : scbc_top
`default_nettype wire

// ==== scbc_top_bench.sv ====
`default_nettype none
module scbc_top_bench
	import scbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic       clk_sys, rst_n, pll_bw_pin, cfg_hold, scl, pull, sda_i, sda_o, sda_oe;
	scbc_ctrl_t ctrl;
	int         n_errors, comparisons;

	// pull-up on the data line
	assign sda_i = !(sda_oe || pull);

	initial clk_sys = 1'b0;
	always #25 clk_sys = !clk_sys;

	// identity values are arbitrary
	scbc_top #(.REVISION_CODE(4'h9), .MAKER_CODE(4'h2), .PART_CODE(8'h6C), .WR_DEPTH(32)) u_scbc_top (
		.clk_sys, .rst_n, .smb_clk(scl), .sda_i, .sda_o, .sda_oe, .pll_bw_pin, .cfg_hold, .ctrl);
	scbc_host u_scbc_host (.scl, .pull, .sda(sda_i));

	////////////////////////////////////////
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: byte %h, want %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_flag(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: ack %b, want %b", $time, got, exp);
		end
	endtask : chk_flag

	task automatic end_of_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	task automatic send(input logic [7:0] b, input logic exp);
		logic a;
		u_scbc_host.put(b, a);
		chk_flag(a, exp);
	endtask : send

	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d[$], input logic last_ack);
		u_scbc_host.bus_start();
		send(ADDR_WR, 1'b1);
		send(idx, 1'b1);
		send(8'(d.size()), 1'b1);
		foreach (d[i]) send(d[i], (i < d.size() - 1) || last_ack);
		u_scbc_host.bus_stop();
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] idx, input logic [7:0] e[$]);
		logic [7:0] b;
		u_scbc_host.bus_start();
		send(ADDR_WR, 1'b1);
		send(idx, 1'b1);
		u_scbc_host.bus_rstart();
		send(ADDR_RD, 1'b1);
		u_scbc_host.get(e.size() == 0, b);
		chk_byte(b, 8'(e.size()));
		foreach (e[i]) begin
			u_scbc_host.get(i == e.size() - 1, b);
			chk_byte(b, e[i]);
		end
		u_scbc_host.bus_stop();
	endtask : reg_rd

	task automatic chk_ctrl(input int cyc, input logic [6:0] exp);
		repeat (cyc) @(negedge clk_sys);
		chk_byte({1'b0, ctrl}, {1'b0, exp});
	endtask : chk_ctrl

	////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_errors++;
		$display("unexpected at %0t: run did not finish", $time);
		end_of_test();
	end

	initial begin
		rst_n = 1'b1;
		pll_bw_pin = 1'b1;
		cfg_hold = 1'b0;
		n_errors = 0;
		comparisons = 0;
		// a real falling edge, so no flop can miss the reset at time zero
		#1 rst_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		chk_ctrl(4, 7'h7F);
		reg_rd(OFS_PLL, '{RST_PLL, RST_OEN, RST_RSV, 8'h92, 8'h6C, RST_LEN});
		reg_wr(OFS_PLL, '{8'h42, 8'h25}, 1'b1);
		chk_ctrl(20, 7'h2B);
		reg_wr(OFS_RSV, '{8'h5A, 8'hFF, 8'hFF, 8'h03}, 1'b1);
		reg_rd(OFS_OEN, '{8'h25, 8'h5A, 8'h92});
		@(negedge clk_sys);
		pll_bw_pin = 1'b0;
		chk_ctrl(20, 7'h2B);
		reg_wr(OFS_PLL, '{8'h80}, 1'b1);
		chk_ctrl(20, 7'h5B);
		pll_bw_pin = 1'b1;
		chk_ctrl(20, 7'h7B);
		// held drain: one control write plus fill of the 32-word buffer
		cfg_hold = 1'b1;
		reg_wr(OFS_OEN, '{8'h00}, 1'b1);
		for (int i = 0; i < 32; i++) reg_wr(OFS_RSV, '{8'(i)}, i < 31);
		chk_ctrl(2, 7'h7B);
		cfg_hold = 1'b0;
		chk_ctrl(200, 7'h70);
		// zero count refuses the next byte; reserved byte keeps its value
		u_scbc_host.bus_start();
		send(ADDR_WR, 1'b1);
		send(OFS_RSV, 1'b1);
		send(8'h00, 1'b1);
		send(8'h77, 1'b0);
		u_scbc_host.bus_stop();
		reg_rd(OFS_RSV, '{8'h1E, 8'h92, 8'h6C});
		reg_rd(OFS_LEN, '{8'h03, 8'h00, 8'h00});
		u_scbc_host.bus_start();
		send(8'hA0, 1'b0);
		u_scbc_host.bus_stop();
		// read address with no index earlier in the frame
		u_scbc_host.bus_start();
		send(ADDR_RD, 1'b0);
		u_scbc_host.bus_stop();
		end_of_test();
	end
endmodule : scbc_top_bench
`default_nettype wire
